//--- core/nbis_boot_search.v
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "nbis_defines.vh"

// ==========================================================
// nand boot image search sequencer
// ==========================================================
module nbis_boot_search (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output wire o_irq,
  input wire [7:0] i_boot_pins,
  input wire i_por_rst,
  input wire i_test_rst_b,
  output wire [7:0] o_boot_cfg,
  output wire [7:0] o_boot_pull_up,
  output wire [7:0] o_boot_pull_dn,
  output wire [7:0] o_misc_pull_up,
  output wire [7:0] o_misc_pull_dn,
  output reg o_emp_req,
  output reg o_emp_cmd,
  output wire [9:0] o_emp_blk,
  output reg [5:0] o_emp_page,
  input wire i_emp_mark_vld,
  input wire i_emp_mark_bad,
  input wire i_emp_seg_vld,
  input wire [`NBIS_ECC_W-1:0] i_emp_ecc,
  input wire [`NBIS_ECC_W-1:0] i_emp_par,
  input wire i_emp_page_done,
  output reg o_fix_vld,
  output reg [`NBIS_USER_W-1:0] o_fix_mask,
  output wire o_busy,
  output wire o_boot_done,
  output wire o_boot_fail
);

  // ========================================================
  // states
  // ========================================================
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_MARK = 3'h1; // spare-area marker read
  localparam [2:0] ST_PAGE = 3'h2; // page read in flight
  localparam [2:0] ST_NEXT = 3'h3; // advance to next block
  localparam [2:0] ST_DONE = 3'h4;
  localparam [2:0] ST_FAIL = 3'h5;

  // ========================================================
  // declarations
  // ========================================================
  reg [2:0] state_r; // sequencer state
  reg [2:0] state_nxt;
  reg [5:0] tries_r; // blocks looked at so far
  reg [9:0] start_blk_r; // first block of the search
  reg [5:0] page_r; // page within current block
  reg pg_unc_r; // page saw an unrepairable segment
  reg pg_eccerr_r; // page saw an ecc-byte error
  reg fix_mode_r; // corrected handling in force
  reg ctrl_fix_r; // software mode choice
  reg [15:0] pull_sel_r; // pull_select_reg, 1 = pull up
  reg [5:0] img_pages_r; // pages making up the image
  reg [2:0] irq_stat_r; // sticky events
  reg [2:0] irq_mask_r; // event enables
  reg [2:0] irq_ev; // events this cycle
  reg [7:0] boot_config_latch; // boot mode pins at power-on
  reg [7:0] pin_s1_r; // pin synchroniser stage one
  reg [7:0] pin_s2_r; // pin synchroniser stage two
  reg por_s1_r;
  reg por_s2_r;
  reg trst_s1_r;
  reg trst_s2_r;
  wire [6:0] seg_cnt; // bit errors in segment
  wire seg_ecc_err;
  wire seg_unc;
  wire [`NBIS_USER_W-1:0] seg_mask;
  wire wr_ctrl;
  wire start_req;
  wire last_page;

  // ========================================================
  // segment checker
  // ========================================================
  nbis_ecc_check u_ecc (
    .i_stored(i_emp_ecc),
    .i_parity(i_emp_par),
    .o_err_cnt(seg_cnt),
    .o_ecc_err(seg_ecc_err),
    .o_uncorr(seg_unc),
    .o_fix_mask(seg_mask)
  );

  // ========================================================
  // boot pin capture
  // ========================================================
  // pins and reset-controller levels, two stages each
  always @(posedge i_ref_clk) begin
    pin_s1_r <= i_boot_pins;
    pin_s2_r <= pin_s1_r;
    por_s1_r <= i_por_rst;
    por_s2_r <= por_s1_r;
    trst_s1_r <= i_test_rst_b;
    trst_s2_r <= trst_s1_r;
  end

  // loads only in power-on reset with test reset low; warm reset keeps it
  always @(posedge i_ref_clk) begin
    if (por_s2_r && !trst_s2_r) begin
      boot_config_latch <= pin_s2_r;
    end
  end
  assign o_boot_cfg = boot_config_latch;

  // ========================================================
  // pull control
  // ========================================================
  // all pins pulled down while reset is held
  assign o_misc_pull_up = i_rst_b ? pull_sel_r[15:8] : 8'h00;
  assign o_misc_pull_dn = ~o_misc_pull_up;
  // select register is defined at release, so boot pins pull down
  assign o_boot_pull_up = i_rst_b ? pull_sel_r[7:0] : 8'h00;
  assign o_boot_pull_dn = ~o_boot_pull_up;

  // ========================================================
  // register bus decode
  // ========================================================
  assign wr_ctrl = i_wr && (i_addr == `NBIS_ADDR_CTRL);
  assign start_req = wr_ctrl && i_wdata[`NBIS_CTRL_START] && !o_busy;

  // software-written registers
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_fix_r <= 1'b0;
      pull_sel_r <= `NBIS_RST_PULL_SEL;
      img_pages_r <= `NBIS_RST_IMG_PAGES;
      irq_mask_r <= `NBIS_RST_IRQ_MASK;
    end else if (i_wr) begin
      case (i_addr)
        `NBIS_ADDR_CTRL: begin
          ctrl_fix_r <= i_wdata[`NBIS_CTRL_FIX];
        end
        `NBIS_ADDR_PULL_SEL: begin
          pull_sel_r <= i_wdata[15:0];
        end
        `NBIS_ADDR_IMG_PAGES: begin
          img_pages_r <= i_wdata[5:0];
        end
        `NBIS_ADDR_IRQ_MASK: begin
          irq_mask_r <= i_wdata[2:0];
        end
        default: begin
          img_pages_r <= img_pages_r; // unmapped writes ignored
        end
      endcase
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `NBIS_ADDR_CTRL: begin
          o_rdata <= {30'h00000000, ctrl_fix_r, 1'b0};
        end
        `NBIS_ADDR_STATUS: begin
          o_rdata <= {12'h000, page_r, o_emp_blk, fix_mode_r, o_boot_fail,
                      o_boot_done, o_busy};
        end
        `NBIS_ADDR_IRQ_STAT: begin
          o_rdata <= {29'h00000000, irq_stat_r};
        end
        `NBIS_ADDR_IRQ_MASK: begin
          o_rdata <= {29'h00000000, irq_mask_r};
        end
        `NBIS_ADDR_BOOT_CFG: begin
          o_rdata <= {24'h000000, boot_config_latch};
        end
        `NBIS_ADDR_PULL_SEL: begin
          o_rdata <= {16'h0000, pull_sel_r};
        end
        `NBIS_ADDR_IMG_PAGES: begin
          o_rdata <= {26'h0000000, img_pages_r};
        end
        default: begin
          o_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // ========================================================
  // interrupts
  // ========================================================
  // sticky bits, write one clears, a new event wins over the clear
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_r <= 3'h0;
    end else if (i_wr && (i_addr == `NBIS_ADDR_IRQ_STAT)) begin
      irq_stat_r <= (irq_stat_r & ~i_wdata[2:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end
  assign o_irq = |(irq_stat_r & irq_mask_r);

  // ========================================================
  // search sequencer
  // ========================================================
  assign last_page = (page_r + 6'h01 >= img_pages_r);
  assign o_emp_blk = start_blk_r + {4'h0, tries_r};
  assign o_busy = (state_r == ST_MARK) || (state_r == ST_PAGE) || (state_r == ST_NEXT);
  assign o_boot_done = (state_r == ST_DONE);
  assign o_boot_fail = (state_r == ST_FAIL);

  // next state and events
  always @* begin
    state_nxt = state_r;
    irq_ev = 3'h0;
    case (state_r)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        if (start_req) begin
          state_nxt = ST_MARK;
        end
      end
      ST_MARK: begin
        if (i_emp_mark_vld) begin
          if (i_emp_mark_bad) begin
            state_nxt = ST_NEXT;
          end else begin
            state_nxt = ST_PAGE;
          end
        end
      end
      ST_PAGE: begin
        if (i_emp_page_done) begin
          if (page_r == 6'h00) begin
            if (pg_unc_r || pg_eccerr_r) begin
              state_nxt = ST_NEXT;
            end else if (last_page) begin
              state_nxt = ST_DONE;
            end
          end else if (!fix_mode_r) begin
            if (pg_unc_r || pg_eccerr_r) begin
              state_nxt = ST_FAIL;
            end else if (last_page) begin
              state_nxt = ST_DONE;
            end
          end else begin
            if (pg_unc_r) begin
              state_nxt = ST_NEXT;
            end else if (last_page) begin
              state_nxt = ST_DONE;
            end
          end
        end
      end
      ST_NEXT: begin
        irq_ev[`NBIS_IRQ_SKIP] = 1'b1;
        if (tries_r + 6'h01 >= `NBIS_MAX_BLOCKS) begin
          state_nxt = ST_FAIL;
        end else begin
          state_nxt = ST_MARK;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if ((state_nxt == ST_DONE) && (state_r != ST_DONE)) begin
      irq_ev[`NBIS_IRQ_DONE] = 1'b1;
    end
    if ((state_nxt == ST_FAIL) && (state_r != ST_FAIL)) begin
      irq_ev[`NBIS_IRQ_FAIL] = 1'b1;
    end
  end

  // state, counters and flash requests
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      tries_r <= 6'h00;
      start_blk_r <= 10'h000;
      page_r <= 6'h00;
      fix_mode_r <= 1'b0;
      o_emp_req <= 1'b0;
      o_emp_cmd <= 1'b0;
      o_emp_page <= 6'h00;
    end else begin
      state_r <= state_nxt;
      o_emp_req <= 1'b0;
      if (start_req) begin
        tries_r <= 6'h00;
        // block zero when boot mode bit 6 is set
        start_blk_r <= boot_config_latch[`NBIS_CFG_BLK0] ? 10'h000
                       : `NBIS_ALT_START_BLK;
        fix_mode_r <= 1'b0;
      end
      if (state_r == ST_NEXT) begin
        tries_r <= tries_r + 6'h01;
        fix_mode_r <= 1'b0;
      end
      if ((state_nxt == ST_MARK) && (state_r != ST_MARK)) begin
        o_emp_req <= 1'b1; // bad-block marker read
        o_emp_cmd <= 1'b0;
      end
      if ((state_r == ST_MARK) && (state_nxt == ST_PAGE)) begin
        page_r <= 6'h00; // first page before any other
        o_emp_req <= 1'b1;
        o_emp_cmd <= 1'b1;
        o_emp_page <= 6'h00;
      end
      if ((state_r == ST_PAGE) && i_emp_page_done && (state_nxt == ST_PAGE)) begin
        if (page_r == 6'h00) begin
          fix_mode_r <= ctrl_fix_r;
        end
        page_r <= page_r + 6'h01;
        o_emp_req <= 1'b1; // later pages of the block
        o_emp_cmd <= 1'b1;
        o_emp_page <= page_r + 6'h01;
      end
    end
  end

  // ========================================================
  // per-page error tracking and repair
  // ========================================================
  // each 512-byte segment arrives with its stored ecc bytes
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pg_unc_r <= 1'b0;
      pg_eccerr_r <= 1'b0;
      o_fix_vld <= 1'b0;
      o_fix_mask <= {`NBIS_USER_W{1'b0}};
    end else begin
      o_fix_vld <= 1'b0;
      if (o_emp_req) begin
        pg_unc_r <= 1'b0;
        pg_eccerr_r <= 1'b0;
      end else if ((state_r == ST_PAGE) && i_emp_seg_vld) begin
        pg_unc_r <= pg_unc_r | seg_unc;
        pg_eccerr_r <= pg_eccerr_r | seg_ecc_err;
        o_fix_vld <= !seg_unc && (seg_cnt != 7'h00);
        o_fix_mask <= seg_mask;
      end
    end
  end

endmodule // nbis_boot_search

//--- core/nbis_defines.vh
// ==========================================================
// nand boot image search constants
// ==========================================================
`ifndef NBIS_DEFINES_VH
`define NBIS_DEFINES_VH

// ==========================================================
// register byte offsets
// ==========================================================
`define NBIS_ADDR_CTRL 8'h00
`define NBIS_ADDR_STATUS 8'h04
`define NBIS_ADDR_IRQ_STAT 8'h08
`define NBIS_ADDR_IRQ_MASK 8'h0C
`define NBIS_ADDR_BOOT_CFG 8'h10
`define NBIS_ADDR_PULL_SEL 8'h14
`define NBIS_ADDR_IMG_PAGES 8'h18

// ==========================================================
// field positions
// ==========================================================
`define NBIS_CTRL_START 0
`define NBIS_CTRL_FIX 1
`define NBIS_IRQ_DONE 0
`define NBIS_IRQ_FAIL 1
`define NBIS_IRQ_SKIP 2
`define NBIS_CFG_BLK0 6

// ==========================================================
// reset values
// ==========================================================
`define NBIS_RST_PULL_SEL 16'h0000
`define NBIS_RST_IMG_PAGES 6'h01
`define NBIS_RST_IRQ_MASK 3'h0

// ==========================================================
// search limits and ecc geometry
// ==========================================================
`define NBIS_MAX_BLOCKS 6'h20
`define NBIS_MAX_BITERR 7'h04
`define NBIS_SEG_BYTES 10'h200
`define NBIS_ECC_W 80
`define NBIS_USER_W 72
`define NBIS_ALT_START_BLK 10'h001

`endif

//--- core/nbis_ecc_check.v
`timescale 1ns/1ps
`include "nbis_defines.vh"

// ==========================================================
// segment syndrome check and correction mask
// ==========================================================
module nbis_ecc_check (
  input wire [`NBIS_ECC_W-1:0] i_stored,
  input wire [`NBIS_ECC_W-1:0] i_parity,
  output reg [6:0] o_err_cnt,
  output wire o_ecc_err,
  output wire o_uncorr,
  output wire [`NBIS_USER_W-1:0] o_fix_mask
);

  wire [`NBIS_ECC_W-1:0] syn; // stored ecc against computed parity
  integer k;

  assign syn = i_stored ^ i_parity;

  // count flipped bits across user and ecc bytes
  always @* begin
    o_err_cnt = 7'h00;
    for (k = 0; k < `NBIS_ECC_W; k = k + 1) begin
      o_err_cnt = o_err_cnt + {6'h00, syn[k]};
    end
  end

  // syndrome bits above user field point into the ecc bytes
  assign o_ecc_err = |syn[`NBIS_ECC_W-1:`NBIS_USER_W];
  // more than four bits in total cannot be repaired
  assign o_uncorr = (o_err_cnt > `NBIS_MAX_BITERR);
  // flip mask for user data, empty when beyond repair
  assign o_fix_mask = o_uncorr ? {`NBIS_USER_W{1'b0}} : syn[`NBIS_USER_W-1:0];

endmodule // nbis_ecc_check

//--- testbench/nbis_boot_search_assertions.sv
`timescale 1ns/1ps
`include "nbis_defines.vh"
// ==========================================================
// port checker for the boot search sequencer
// ==========================================================
module nbis_boot_search_assertions (
  input logic i_ref_clk,
  input logic i_rst_b,
  input logic i_rd,
  input logic [31:0] o_rdata,
  input logic i_por_rst,
  input logic [7:0] o_boot_cfg,
  input logic [7:0] o_boot_pull_up,
  input logic [7:0] o_boot_pull_dn,
  input logic [7:0] o_misc_pull_up,
  input logic [7:0] o_misc_pull_dn,
  input logic o_emp_req,
  input logic o_emp_cmd,
  input logic [9:0] o_emp_blk,
  input logic [5:0] o_emp_page,
  input logic i_emp_mark_vld,
  input logic i_emp_mark_bad,
  input logic i_emp_seg_vld,
  input logic [`NBIS_ECC_W-1:0] i_emp_ecc,
  input logic [`NBIS_ECC_W-1:0] i_emp_par,
  input logic o_fix_vld,
  input logic [`NBIS_USER_W-1:0] o_fix_mask,
  input logic o_busy,
  input logic o_boot_done,
  input logic o_boot_fail
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire [`NBIS_ECC_W-1:0] syn = i_emp_ecc ^ i_emp_par; // segment syndrome
  wire [`NBIS_USER_W-1:0] syn_user = syn[`NBIS_USER_W-1:0];
  logic [3:0] quiet_r; // cycles since power-on reset ended
  logic p0_ok_r; // first page of current block was requested
  logic [9:0] p0_blk_r;
  logic [9:0] mark_blk_r; // block of the last marker answer
  // ==========================================================
  // helper logic
  // ==========================================================
  always @(posedge i_ref_clk) begin
    if (i_por_rst) quiet_r <= 4'h0;
    else if (quiet_r != 4'h8) quiet_r <= quiet_r + 4'h1;
    if (i_emp_mark_vld) mark_blk_r <= o_emp_blk;
  end
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      p0_ok_r <= 1'b0;
      p0_blk_r <= 10'h000;
    end else if (o_emp_req) begin
      p0_ok_r <= o_emp_cmd && (o_emp_page == 6'h00 || p0_ok_r);
      if (o_emp_cmd && o_emp_page == 6'h00) p0_blk_r <= o_emp_blk;
    end
  end
  sequence s_mark_good;
    i_emp_mark_vld && !i_emp_mark_bad && o_busy && !o_emp_cmd;
  endsequence
  sequence s_first_page_req;
    o_emp_req && o_emp_cmd && o_emp_page == 6'h00;
  endsequence
  // ==========================================================
  // assertions
  // ==========================================================
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_pull_release_down: assert property ($rose(i_rst_b) |-> o_boot_pull_dn == 8'hFF && o_boot_pull_up == 8'h00 && o_misc_pull_dn == 8'hFF && o_misc_pull_up == 8'h00)
    else $error("pins not pulled down at reset release");
  a_cfg_hold_warm: assert property (quiet_r == 4'h8 |-> $stable(o_boot_cfg))
    else $error("boot config changed without power-on reset");
  a_fix_has_cause: assert property (o_fix_vld |-> $past(i_emp_seg_vld))
    else $error("correction pulse without segment");
  a_fix_mask_exact: assert property (i_emp_seg_vld && o_busy && o_emp_cmd && $countones(syn) inside {[1:4]} && syn[79:72] == 8'h00 |=> o_fix_vld && o_fix_mask == $past(syn_user))
    else $error("correction mask wrong");
  a_first_page_next: assert property (s_mark_good |=> s_first_page_req)
    else $error("good marker not followed by first page");
  a_page_order_blk: assert property (o_emp_req && o_emp_cmd && o_emp_page != 6'h00 |-> p0_ok_r && p0_blk_r == o_emp_blk)
    else $error("later page before first page");
  a_bad_skip_next: assert property (i_emp_mark_vld && i_emp_mark_bad && o_busy && !o_emp_cmd |-> ##[1:6] ((o_emp_req && !o_emp_cmd && o_emp_blk == mark_blk_r + 10'h001) || o_boot_fail))
    else $error("bad block not skipped");
  a_state_onehot: assert property ($onehot0({o_busy, o_boot_done, o_boot_fail}))
    else $error("busy done fail overlap");
endmodule // nbis_boot_search_assertions

//--- testbench/nbis_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// behavioural flash behind the external memory port
// ==========================================================
module nbis_flash_model (
  input logic i_clk,
  input logic i_rst_b,
  input logic i_req,
  input logic i_cmd,
  input logic [9:0] i_blk,
  input logic [5:0] i_page,
  input logic [31:0] i_bad,
  input logic [9:0] i_err_blk,
  input logic [5:0] i_err_page,
  input logic [1:0] i_err_kind,
  input logic [3:0] i_lat,
  output logic o_mark_vld,
  output logic o_mark_bad,
  output logic o_seg_vld,
  output logic o_page_done,
  output logic [79:0] o_ecc,
  output logic [79:0] o_par
);
  localparam logic [79:0] PAT = {10{8'hA5}}; // computed parity of the data
  logic act_r, cmd_r; // request in progress and its kind
  logic [1:0] ph_r; // page phase: segment, gap, done
  logic [3:0] cnt_r; // answer latency countdown
  logic [9:0] blk_r;
  logic [5:0] pg_r;
  logic [79:0] syn; // injected syndrome
  // ==========================================================
  // error injection for one chosen page
  // ==========================================================
  always @* begin
    syn = 80'h0;
    if (blk_r == i_err_blk && pg_r == i_err_page) begin
      case (i_err_kind)
        2'h1: syn = 80'h21; // two user bits
        2'h2: syn = 80'h0800_0000_0000_0000_0000; // one ecc-byte bit
        2'h3: syn = 80'h1F; // five bits, beyond repair
        default: syn = 80'h0;
      endcase
    end
  end
  // ==========================================================
  // answer engine
  // ==========================================================
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      act_r <= 1'b0;
      o_mark_vld <= 1'b0;
      o_mark_bad <= 1'b0;
      o_seg_vld <= 1'b0;
      o_page_done <= 1'b0;
      o_ecc <= 80'h0;
      o_par <= '1;
    end else begin
      o_mark_vld <= 1'b0;
      o_seg_vld <= 1'b0;
      o_page_done <= 1'b0;
      o_ecc <= ~o_ecc; // idle lines wander
      o_par <= ~o_par;
      o_mark_bad <= ~o_mark_bad;
      if (i_req) begin
        act_r <= 1'b1;
        cmd_r <= i_cmd;
        blk_r <= i_blk;
        pg_r <= i_page;
        cnt_r <= i_lat;
        ph_r <= 2'h0;
      end else if (act_r && cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      else if (act_r && !cmd_r) begin
        o_mark_vld <= 1'b1;
        o_mark_bad <= i_bad[blk_r[4:0]];
        act_r <= 1'b0;
      end else if (act_r) begin
        ph_r <= ph_r + 2'h1;
        if (ph_r == 2'h0) begin
          o_seg_vld <= 1'b1;
          o_par <= PAT;
          o_ecc <= PAT ^ syn;
        end
        if (ph_r == 2'h2) begin
          o_page_done <= 1'b1;
          act_r <= 1'b0;
        end
      end
    end
  end
endmodule // nbis_flash_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`include "nbis_defines.vh"
module tb_top;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, por = 1, trst_b = 0;
  logic [7:0] addr = 0, pins = 8'h40;
  logic [31:0] wdata = 0, m_bad = 0;
  logic [9:0] m_eblk = 0;
  logic [5:0] m_epg = 6'h3F;
  logic [1:0] m_kind = 0;
  logic [3:0] m_lat = 0;
  wire [31:0] rdata;
  wire [7:0] cfg, bpu, bpd, mpu, mpd;
  wire irq, req, cmd, mvld, mbad, svld, pdone, fvld, busy, done, fail;
  wire [9:0] blk;
  wire [5:0] pg;
  wire [`NBIS_ECC_W-1:0] ecc, par;
  wire [`NBIS_USER_W-1:0] fmask;
  int err_total = 0, compares = 0, marks = 0, nmark = 0;
  logic [71:0] fm_seen = 0; // last correction mask seen on the port
  always #12.5 clk = ~clk;
  nbis_boot_search DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_boot_pins(pins), .i_por_rst(por),
    .i_test_rst_b(trst_b), .o_boot_cfg(cfg), .o_boot_pull_up(bpu), .o_boot_pull_dn(bpd),
    .o_misc_pull_up(mpu), .o_misc_pull_dn(mpd), .o_emp_req(req), .o_emp_cmd(cmd),
    .o_emp_blk(blk), .o_emp_page(pg), .i_emp_mark_vld(mvld), .i_emp_mark_bad(mbad),
    .i_emp_seg_vld(svld), .i_emp_ecc(ecc), .i_emp_par(par), .i_emp_page_done(pdone),
    .o_fix_vld(fvld), .o_fix_mask(fmask), .o_busy(busy), .o_boot_done(done), .o_boot_fail(fail));
  nbis_flash_model u_flash (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_cmd(cmd), .i_blk(blk),
    .i_page(pg), .i_bad(m_bad), .i_err_blk(m_eblk), .i_err_page(m_epg), .i_err_kind(m_kind),
    .i_lat(m_lat), .o_mark_vld(mvld), .o_mark_bad(mbad), .o_seg_vld(svld),
    .o_page_done(pdone), .o_ecc(ecc), .o_par(par));
  // marker requests seen on the port
  always @(posedge clk) if (req === 1'b1 && cmd === 1'b0) marks <= marks + 1;
  // correction masks seen on the port
  always @(posedge clk) if (fvld === 1'b1) fm_seen <= fmask;
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // reset with or without power-on capture
  task automatic do_reset(input logic p, input logic [7:0] v, input logic [7:0] e);
    @(posedge clk);
    rst_b <= 1'b0; por <= p; trst_b <= !p; pins <= v;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({bpd, mpd, bpu, mpu}, 32'hFFFF_0000);
    @(posedge clk);
    rst_b <= 1'b1; por <= 1'b0;
    repeat (4) @(posedge clk);
    trst_b <= 1'b1;
    @(negedge clk);
    chk(cfg, e);
  endtask
  // one search with an error on one page, judged at its end
  task automatic srch(input logic fix, input logic [5:0] epg, input logic [1:0] kind,
                      input logic efail, input logic [9:0] eblk);
    int n;
    int m0;
    m_epg <= epg; m_kind <= kind; m0 = marks; n = 0;
    wr_reg(`NBIS_ADDR_CTRL, {30'h0, fix, 1'b1});
    @(negedge clk);
    while (done !== 1'b1 && fail !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(done | fail, 1'b1);
    chk(fail, efail);
    if (eblk != 10'h3FF) chk(blk, eblk);
    nmark = marks - m0;
  endtask
  initial begin
    do_reset(1'b1, 8'h40, 8'h40);
    rd_reg(`NBIS_ADDR_BOOT_CFG, 32'h40);
    rd_reg(`NBIS_ADDR_PULL_SEL, 32'h0);
    rd_reg(`NBIS_ADDR_IMG_PAGES, 32'h1);
    rd_reg(8'h1C, 32'h0);
    wr_reg(`NBIS_ADDR_PULL_SEL, 32'h0F0F);
    @(negedge clk);
    chk({bpu, mpu}, 16'h0F0F);
    wr_reg(`NBIS_ADDR_PULL_SEL, 32'h0);
    wr_reg(`NBIS_ADDR_IMG_PAGES, 32'h3);
    m_bad <= 32'h3; m_eblk <= 10'h2; m_lat <= 4'h3;
    srch(1'b0, 6'h1, 2'h1, 1'b0, 10'h2);
    chk(pg, 6'h2);
    chk(fm_seen, 72'h21);
    rd_reg(`NBIS_ADDR_STATUS, 32'h8022);
    chk(irq, 1'b0);
    wr_reg(`NBIS_ADDR_IRQ_MASK, 32'h7);
    @(negedge clk);
    chk(irq, 1'b1);
    rd_reg(`NBIS_ADDR_IRQ_STAT, 32'h5);
    wr_reg(`NBIS_ADDR_IRQ_STAT, 32'h7);
    @(negedge clk);
    chk(irq, 1'b0);
    m_bad <= 32'h0; m_eblk <= 10'h0; m_lat <= 4'h0;
    srch(1'b0, 6'h0, 2'h3, 1'b0, 10'h1);
    srch(1'b0, 6'h0, 2'h2, 1'b0, 10'h1);
    srch(1'b0, 6'h1, 2'h2, 1'b1, 10'h0);
    srch(1'b0, 6'h1, 2'h3, 1'b1, 10'h0);
    srch(1'b1, 6'h1, 2'h2, 1'b0, 10'h0);
    srch(1'b1, 6'h1, 2'h3, 1'b0, 10'h1);
    m_bad <= '1;
    srch(1'b0, 6'h3F, 2'h0, 1'b1, 10'h3FF);
    chk(nmark, 32);
    m_bad <= 32'h0;
    do_reset(1'b0, 8'h00, 8'h40);
    do_reset(1'b1, 8'h20, 8'h20);
    srch(1'b0, 6'h3F, 2'h0, 1'b0, 10'h1);
    end_of_test;
  end
  initial begin
    #(25 * 20000);
    err_total++;
    end_of_test;
  end
endmodule // tb_top
bind nbis_boot_search nbis_boot_search_assertions u_chk (.i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rdata(o_rdata), .i_por_rst(i_por_rst),
  .o_boot_cfg(o_boot_cfg), .o_boot_pull_up(o_boot_pull_up), .o_boot_pull_dn(o_boot_pull_dn),
  .o_misc_pull_up(o_misc_pull_up), .o_misc_pull_dn(o_misc_pull_dn), .o_emp_req(o_emp_req),
  .o_emp_cmd(o_emp_cmd), .o_emp_blk(o_emp_blk), .o_emp_page(o_emp_page),
  .i_emp_mark_vld(i_emp_mark_vld), .i_emp_mark_bad(i_emp_mark_bad),
  .i_emp_seg_vld(i_emp_seg_vld), .i_emp_ecc(i_emp_ecc), .i_emp_par(i_emp_par),
  .o_fix_vld(o_fix_vld), .o_fix_mask(o_fix_mask), .o_busy(o_busy),
  .o_boot_done(o_boot_done), .o_boot_fail(o_boot_fail));
